// >>> bench/fpu_special_register_file_tb.sv
`include "fpu_regs_params.svh"
`timescale 1ns/1ns
`default_nettype none

module fpu_special_register_file_tb;
  logic                      mclk_i;
  logic                      srst_i;
  logic                      ce_i;
  logic                      user_mode_i;
  logic                      int_taken_i;
  fpu_regs_pkg::cop_req_t    cop_req_i;
  logic [63:0]               cop_data_i;
  logic                      claim_o;
  logic [63:0]               cop_data_o;
  logic                      cop_data_oe_o;
  logic                      writeback_stage_advance_o;
  logic                      alu_valid_i;
  fpu_regs_pkg::alu_instr_t  alu_instr_i;
  logic                      alu_ready_o;
  logic                      issue_valid_o;
  logic [3:0]                issue_opcode_o;
  logic [5:0]                issue_dest_o;
  logic [63:0]               issue_a_o;
  logic [63:0]               issue_b_o;
  fpu_regs_pkg::alu_result_t result_i;
  logic                      interrupt_o;
  int                        error_cnt;
  int                        checks;
  logic [63:0]               d;
  logic [63:0]               t1;
  logic [63:0]               t2;
  logic [63:0]               v5;
  logic [63:0]               first_a;
  logic [63:0]               first_b;
  logic [3:0]                first_op;
  logic [5:0]                last_dest;
  logic                      ready_after;
  int                        issued;
  int                        n;

  fpu_special_register_file DUT (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .user_mode_i(user_mode_i),
    .int_taken_i(int_taken_i), .cop_req_i(cop_req_i), .cop_data_i(cop_data_i), .claim_o(claim_o),
    .cop_data_o(cop_data_o), .cop_data_oe_o(cop_data_oe_o), .writeback_stage_advance_o(writeback_stage_advance_o),
    .alu_valid_i(alu_valid_i), .alu_instr_i(alu_instr_i), .alu_ready_o(alu_ready_o), .issue_valid_o(issue_valid_o),
    .issue_opcode_o(issue_opcode_o), .issue_dest_o(issue_dest_o), .issue_a_o(issue_a_o), .issue_b_o(issue_b_o),
    .result_i(result_i), .interrupt_o(interrupt_o));

  host_cpu_model cpu (.mclk_i(mclk_i), .claim_i(claim_o), .data_i(cop_data_o), .data_oe_i(cop_data_oe_o),
    .advance_i(writeback_stage_advance_o), .req_o(cop_req_i), .data_o(cop_data_i));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rd(input fpu_regs_pkg::cop_op_t op, input logic [5:0] r, output logic [63:0] v);
    logic ok;
    cpu.read_reg(op, r, v, ok);
    check(64'(ok), 64'h1);
    if (!ok)
      summarize();
  endtask

  function automatic fpu_regs_pkg::alu_instr_t mk(input logic [5:0] dst, input logic [5:0] a, input logic [5:0] b,
                                                  input logic [3:0] len, input logic sa, input logic sb);
    return '{opcode: 4'h1, dest: dst, srca: a, srcb: b, len: len, sca: sa, scb: sb};
  endfunction

  // Operands stay inside the register space
  task automatic alu(input fpu_regs_pkg::alu_instr_t ins);
    issued = 0;
    @(negedge mclk_i);
    alu_instr_i = ins;
    alu_valid_i = 1'b1;
    @(negedge mclk_i);
    alu_valid_i = 1'b0;
    ready_after = alu_ready_o;
    for (int i = 0; i < 40 && issued <= int'(ins.len); i++) begin
      @(negedge mclk_i);
      if (issue_valid_o === 1'b1) begin
        if (issued == 0) begin
          first_a  = issue_a_o;
          first_b  = issue_b_o;
          first_op = issue_opcode_o;
        end
        last_dest = issue_dest_o;
        issued++;
      end
    end
    // Too few elements issued within the bound
    if (issued <= int'(ins.len)) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic result(input logic [5:0] dst, input logic [63:0] v, input logic ov, input logic uf);
    @(negedge mclk_i);
    result_i = '{valid: 1'b1, dest: dst, data: v, overflow: ov, underflow: uf};
    @(negedge mclk_i);
    result_i = '{valid: 1'b0, dest: ~dst, data: ~v, overflow: 1'b0, underflow: 1'b0};
  endtask

  task automatic take_int();
    @(negedge mclk_i);
    int_taken_i = 1'b1;
    @(negedge mclk_i);
    int_taken_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    checks = 0;
    srst_i = 1'b1;
    ce_i = 1'b1;
    user_mode_i = 1'b0;
    int_taken_i = 1'b0;
    alu_valid_i = 1'b0;
    alu_instr_i = '0;
    result_i = '0;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    srst_i = 1'b0;
    // Status ignores loads
    cpu.write_reg(fpu_regs_pkg::COP_LOAD, `REG_STATUS, 64'hFFFF_FFFF_FFFF_FFFF);
    check(64'(cpu.last_claim), 64'h1);
    rd(fpu_regs_pkg::COP_STORE, `REG_STATUS, d);
    check(d, 64'h0);
    for (int k = 0; k < 3; k++) begin
      t1 = {26'h0, 6'((k == 0) ? 0 : (k == 1) ? 5 : 51), 32'hA5C3_0F1E};
      cpu.write_reg(fpu_regs_pkg::COP_LOAD, t1[37:32], t1);
      rd(fpu_regs_pkg::COP_STORE, t1[37:32], d);
      check(d, t1);
    end
    v5 = {26'h0, 6'h05, 32'hA5C3_0F1E};
    rd(fpu_regs_pkg::COP_TO_CPU, 6'h05, d);
    check(d, {v5[63:32], 32'h0});
    cpu.write_reg(fpu_regs_pkg::COP_FROM_CPU, 6'h05, 64'h9876_5432_0F0F_0F0F);
    v5 = {32'h9876_5432, v5[31:0]};
    rd(fpu_regs_pkg::COP_STORE, 6'h05, d);
    check(d, v5);
    cpu.write_reg(fpu_regs_pkg::COP_LOAD, 6'h37, 64'h1);
    check(64'(cpu.last_claim), 64'h0);
    cpu.write_reg(fpu_regs_pkg::COP_FROM_CPU, 6'h3F, 64'h1);
    check(64'(cpu.last_claim), 64'h0);
    // Counter rate: two reads three cycles apart
    cpu.write_reg(fpu_regs_pkg::COP_LOAD, `REG_WALL, 64'h0000_0000_0000_1000);
    rd(fpu_regs_pkg::COP_STORE, `REG_WALL, t1);
    rd(fpu_regs_pkg::COP_STORE, `REG_WALL, t2);
    check(t2 - t1, 64'h3);
    check(64'(t1[63:54]), 64'h0);
    check(64'(t1[53:12]), 64'h1);
    rd(fpu_regs_pkg::COP_TO_CPU, `REG_WALL, d);
    check(d, 64'h0);
    // User-mode counter write is refused and trapped
    @(negedge mclk_i);
    user_mode_i = 1'b1;
    cpu.write_reg(fpu_regs_pkg::COP_LOAD, `REG_WALL, 64'h0);
    @(negedge mclk_i);
    check(64'(interrupt_o), 64'h1);
    rd(fpu_regs_pkg::COP_STORE, `REG_WALL, d);
    check(64'(d[53:12]), 64'h1);
    rd(fpu_regs_pkg::COP_STORE, `REG_STATUS, d);
    check(d, 64'h0000_0001_0000_0000);
    take_int();
    check(64'(interrupt_o), 64'h0);
    @(negedge mclk_i);
    user_mode_i = 1'b0;
    // Timer wrap close to all ones
    cpu.write_reg(fpu_regs_pkg::COP_LOAD, `REG_ELAPSED, 64'h003F_FFFF_FFFF_FFF0);
    user_mode_i = 1'b1;
    n = 0;
    while (interrupt_o !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    check(64'(n >= 10 && n <= 20), 64'h1);
    if (n >= 40)
      summarize();
    rd(fpu_regs_pkg::COP_STORE, `REG_ELAPSED, d);
    check(64'(d[63:6]), 64'h0);
    rd(fpu_regs_pkg::COP_STORE, `REG_STATUS, d);
    check(d, 64'h0000_0004_0000_0000);
    take_int();
    user_mode_i = 1'b0;
    // Constant operands
    alu(mk(6'h0A, `REG_STATUS, `REG_WALL, 4'h0, 1'b0, 1'b0));
    check(first_a, `CONST_ZERO);
    check(first_b, `CONST_HALF);
    alu(mk(6'h0B, `REG_ELAPSED, 6'h05, 4'h0, 1'b0, 1'b0));
    check(first_a, `CONST_ONE);
    check(first_b, v5);
    // Store of a pending result stalls writeback
    fork
      rd(fpu_regs_pkg::COP_STORE, 6'h0A, d);
      begin
        repeat (4) @(negedge mclk_i);
        result(6'h0A, 64'h3FF0_1234_5678_9ABC, 1'b0, 1'b0);
      end
    join
    check(64'(cpu.stalled), 64'h1);
    check(d, 64'h3FF0_1234_5678_9ABC);
    result(6'h0B, 64'h1234_5678_9ABC_DEF0, 1'b0, 1'b1);
    check(64'(interrupt_o), 64'h0);
    rd(fpu_regs_pkg::COP_STORE, 6'h0B, d);
    check(d, 64'h0);
    // Overflow then a discarded result
    user_mode_i = 1'b1;
    cpu.write_reg(fpu_regs_pkg::COP_LOAD, 6'h0D, 64'h5555_6666_7777_8888);
    result(6'h0C, 64'h1, 1'b1, 1'b0);
    @(negedge mclk_i);
    check(64'(interrupt_o), 64'h1);
    result(6'h0D, 64'h7777_7777_7777_7777, 1'b0, 1'b0);
    rd(fpu_regs_pkg::COP_STORE, 6'h0D, d);
    check(d, 64'h5555_6666_7777_8888);
    rd(fpu_regs_pkg::COP_STORE, `REG_STATUS, d);
    check(d, 64'h0000_0C02_0000_0000);
    take_int();
    user_mode_i = 1'b0;
    // Vector issue then a constant-target no-op
    alu(mk(6'h14, 6'h05, 6'h05, 4'h2, 1'b1, 1'b1));
    check(64'(ready_after), 64'h0);
    check(64'(issued), 64'h3);
    check(64'(last_dest), 64'h16);
    alu(mk(`REG_STATUS, `REG_WALL, `REG_ELAPSED, 4'h0, 1'b0, 1'b0));
    check(64'(issued), 64'h1);
    check(64'(last_dest), 64'h34);
    check(64'(first_op), 64'h1);
    result(`REG_STATUS, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0, 1'b0);
    rd(fpu_regs_pkg::COP_STORE, `REG_STATUS, d);
    // Overflow destination field outlives the interrupt; flags were cleared
    check(d, 64'h0000_0C00_0000_0000);
    summarize();
  end
endmodule

`default_nettype wire

// >>> bench/host_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

module host_cpu_model (
  // Clock
  input  wire logic                 mclk_i,
  // Answers from the coprocessor
  input  wire logic                 claim_i,
  input  wire logic [63:0]          data_i,
  input  wire logic                 data_oe_i,
  input  wire logic                 advance_i,
  // Requests to the coprocessor
  output var fpu_regs_pkg::cop_req_t req_o,
  output logic [63:0]               data_o
);
  logic last_claim;
  logic stalled;

  initial begin
    req_o = '0;
    data_o = 64'h0;
    last_claim = 1'b0;
    stalled = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write is a one-cycle pulse; the released data bus shows junk
  task automatic write_reg(input fpu_regs_pkg::cop_op_t op, input logic [5:0] regnum, input logic [63:0] data);
    @(negedge mclk_i);
    req_o = '{valid: 1'b1, op: op, regnum: regnum};
    data_o = data;
    @(negedge mclk_i);
    last_claim = claim_i;
    req_o.valid = 1'b0;
    data_o = ~data;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read is held through the edge that samples the answer
  task automatic read_reg(input fpu_regs_pkg::cop_op_t op, input logic [5:0] regnum,
                          output logic [63:0] data, output logic ok);
    ok = 1'b0;
    stalled = 1'b0;
    data = 64'h0;
    @(negedge mclk_i);
    req_o = '{valid: 1'b1, op: op, regnum: regnum};
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge mclk_i);
      if (advance_i === 1'b0)
        stalled = 1'b1;
      if (data_oe_i === 1'b1) begin
        ok = 1'b1;
        data = data_i;
      end
    end
    @(negedge mclk_i);
    req_o.valid = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> core/fpu_regs_params.svh
`ifndef FPU_REGS_PARAMS_SVH
`define FPU_REGS_PARAMS_SVH

// Coprocessor register space
`define GPR_COUNT        52
`define REG_STATUS       6'h34
`define REG_WALL         6'h35
`define REG_ELAPSED      6'h36
`define REG_LAST         6'h36

// Arithmetic constants in G format
`define CONST_ZERO       64'h0000_0000_0000_0000
`define CONST_HALF       64'h4000_0000_0000_0000
`define CONST_ONE        64'h4010_0000_0000_0000

// Status word layout, flags in the high word so transfers see them
`define STAT_PRIV_BIT    32
`define STAT_OVF_BIT     33
`define STAT_TMR_BIT     34
`define STAT_ROV_LSB     40
`define STAT_ROV_MSB     45

// Counters and status reset value
`define CNT_W            54
`define CNT_ZERO_BITS    10
`define CNT_ONES         54'h3F_FFFF_FFFF_FFFF
`define RESET_STATUS     64'h0000_0000_0000_0000

`endif

// >>> core/fpu_regs_pkg.sv
package fpu_regs_pkg;

  typedef enum logic [1:0] {
    COP_LOAD     = 2'b00,
    COP_STORE    = 2'b01,
    COP_TO_CPU   = 2'b10,
    COP_FROM_CPU = 2'b11
  } cop_op_t;

  typedef struct packed {
    logic       valid;
    cop_op_t    op;
    logic [5:0] regnum;
  } cop_req_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [5:0] dest;
    logic [5:0] srca;
    logic [5:0] srcb;
    logic [3:0] len;
    logic       sca;
    logic       scb;
  } alu_instr_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] dest;
    logic [63:0] data;
    logic       overflow;
    logic       underflow;
  } alu_result_t;

endpackage

// >>> core/fpu_special_register_file.sv
`include "fpu_regs_params.svh"
`timescale 1ns/1ns
`default_nettype none

module fpu_special_register_file (
  // Clock and control
  input  wire logic                      mclk_i,
  input  wire logic                      srst_i,
  input  wire logic                      ce_i,
  // Processor state
  input  wire logic                      user_mode_i,
  input  wire logic                      int_taken_i,
  // Coprocessor load, store and transfers
  input  wire fpu_regs_pkg::cop_req_t    cop_req_i,
  input  wire logic [63:0]               cop_data_i,
  output logic                           claim_o,
  output logic [63:0]                    cop_data_o,
  output logic                           cop_data_oe_o,
  output logic                           writeback_stage_advance_o,
  // Arithmetic instruction intake
  input  wire logic                      alu_valid_i,
  input  wire fpu_regs_pkg::alu_instr_t  alu_instr_i,
  output logic                           alu_ready_o,
  // Element issue to functional units
  output logic                           issue_valid_o,
  output logic [3:0]                     issue_opcode_o,
  output logic [5:0]                     issue_dest_o,
  output logic [63:0]                    issue_a_o,
  output logic [63:0]                    issue_b_o,
  // Results back from functional units
  input  wire fpu_regs_pkg::alu_result_t result_i,
  // Interrupt request
  output logic                           interrupt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic is_gpr(input logic [5:0] idx);
    is_gpr = (idx < 6'(`GPR_COUNT));
  endfunction

  function automatic logic in_space(input logic [5:0] idx);
    in_space = (idx <= `REG_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [63:0]              gpr [0:`GPR_COUNT-1];
  logic [`GPR_COUNT-1:0]    busy;
  logic [63:0]              busy_ext;
  logic [`CNT_W-1:0]        wall_time_counter;
  logic [`CNT_W-1:0]        elapsed_cycle_timer;
  logic [63:0]              fpu_status_word;
  logic                     flag_p;
  logic                     flag_o;
  logic                     flag_t;
  logic [5:0]               rov;
  logic                     ir_valid;
  fpu_regs_pkg::alu_instr_t ir;

  assign busy_ext = {{(64 - `GPR_COUNT){1'b0}}, busy};

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic cop_wr;
  logic cop_rd;
  logic cop_claim;
  logic wall_wr;
  logic timer_wr;
  logic priv_viol;
  logic rd_stall;
  logic timer_wrap;
  logic ovf_event;
  logic res_we;

  always_comb begin
    cop_claim  = cop_req_i.valid && in_space(cop_req_i.regnum);
    cop_wr     = cop_claim && (cop_req_i.op == fpu_regs_pkg::COP_LOAD ||
                               cop_req_i.op == fpu_regs_pkg::COP_FROM_CPU);
    cop_rd     = cop_claim && (cop_req_i.op == fpu_regs_pkg::COP_STORE ||
                               cop_req_i.op == fpu_regs_pkg::COP_TO_CPU);
    wall_wr    = cop_wr && !user_mode_i && cop_req_i.regnum == `REG_WALL;
    timer_wr   = cop_wr && !user_mode_i && cop_req_i.regnum == `REG_ELAPSED;
    priv_viol  = cop_wr && user_mode_i &&
                 (cop_req_i.regnum == `REG_WALL || cop_req_i.regnum == `REG_ELAPSED);
    rd_stall   = cop_rd && busy_ext[cop_req_i.regnum];
    timer_wrap = !timer_wr && elapsed_cycle_timer == `CNT_ONES;
    ovf_event  = result_i.valid && result_i.overflow;
    // Discard once an overflow is pending, including the faulting element
    res_we     = result_i.valid && !result_i.overflow && !flag_o && is_gpr(result_i.dest);
  end

  ////////////////////////////////////////////////////////////////////////////
  // General registers

  logic [63:0] res_data;
  assign res_data = result_i.underflow ? `CONST_ZERO : result_i.data;

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      // Load wins a collision, a transfer only in bits 63:32; a result cannot legally target a register being loaded
      if (res_we) begin
        gpr[result_i.dest] <= res_data;
      end
      if (cop_wr && is_gpr(cop_req_i.regnum)) begin
        if (cop_req_i.op == fpu_regs_pkg::COP_LOAD) begin
          gpr[cop_req_i.regnum] <= cop_data_i;
        end else begin
          gpr[cop_req_i.regnum][63:32] <= cop_data_i[63:32];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wall_time_counter <= '0;
    end else if (ce_i) begin
      if (wall_wr && cop_req_i.op == fpu_regs_pkg::COP_LOAD) begin
        wall_time_counter <= cop_data_i[`CNT_W-1:0];
      end else if (wall_wr) begin
        wall_time_counter <= {cop_data_i[`CNT_W-1:32], wall_time_counter[31:0]};
      end else begin
        wall_time_counter <= wall_time_counter + `CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      elapsed_cycle_timer <= '0;
    end else if (ce_i) begin
      if (timer_wr && cop_req_i.op == fpu_regs_pkg::COP_LOAD) begin
        elapsed_cycle_timer <= cop_data_i[`CNT_W-1:0];
      end else if (timer_wr) begin
        elapsed_cycle_timer <= {cop_data_i[`CNT_W-1:32], elapsed_cycle_timer[31:0]};
      end else begin
        elapsed_cycle_timer <= elapsed_cycle_timer + `CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live flags and status word

  logic        next_p;
  logic        next_o;
  logic        next_t;
  logic [5:0]  next_rov;
  logic [63:0] next_status;

  always_comb begin
    // A new event in the clearing cycle survives
    next_p   = priv_viol  || (flag_p && !int_taken_i);
    next_o   = ovf_event  || (flag_o && !int_taken_i);
    next_t   = timer_wrap || (flag_t && !int_taken_i);
    next_rov = (ovf_event && !flag_o) ? result_i.dest : rov;
    next_status = `RESET_STATUS;
    next_status[`STAT_PRIV_BIT] = next_p;
    next_status[`STAT_OVF_BIT]  = next_o;
    next_status[`STAT_TMR_BIT]  = next_t;
    next_status[`STAT_ROV_MSB:`STAT_ROV_LSB] = next_rov;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flag_p      <= 1'b0;
      flag_o      <= 1'b0;
      flag_t      <= 1'b0;
      rov         <= 6'h00;
      interrupt_o <= 1'b0;
    end else if (ce_i) begin
      flag_p      <= next_p;
      flag_o      <= next_o;
      flag_t      <= next_t;
      rov         <= next_rov;
      interrupt_o <= next_p || next_o || next_t;
    end
  end

  // Captures the event cycle itself, since interrupt rises one edge later
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fpu_status_word <= `RESET_STATUS;
    end else if (ce_i && user_mode_i && !interrupt_o) begin
      fpu_status_word <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store and transfer read path

  logic [63:0] rd_value;

  always_comb begin
    if (is_gpr(cop_req_i.regnum)) begin
      rd_value = gpr[cop_req_i.regnum];
    end else if (cop_req_i.regnum == `REG_STATUS) begin
      rd_value = fpu_status_word;
    end else if (cop_req_i.regnum == `REG_WALL) begin
      rd_value = {{`CNT_ZERO_BITS{1'b0}}, wall_time_counter};
    end else begin
      rd_value = {{`CNT_ZERO_BITS{1'b0}}, elapsed_cycle_timer};
    end
    if (cop_req_i.op == fpu_regs_pkg::COP_TO_CPU) begin
      rd_value = {rd_value[63:32], 32'h0000_0000};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      claim_o                   <= 1'b0;
      cop_data_o                <= 64'h0000_0000_0000_0000;
      cop_data_oe_o             <= 1'b0;
      writeback_stage_advance_o <= 1'b1;
    end else if (ce_i) begin
      claim_o                   <= cop_claim;
      cop_data_oe_o             <= cop_rd && !rd_stall;
      writeback_stage_advance_o <= !rd_stall;
      if (cop_rd && !rd_stall) begin
        cop_data_o <= rd_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic instruction register and element issue

  function automatic logic [63:0] operand(input logic [5:0] idx);
    case (idx)
      `REG_STATUS:  operand = `CONST_ZERO;
      `REG_WALL:    operand = `CONST_HALF;
      `REG_ELAPSED: operand = `CONST_ONE;
      default:      operand = is_gpr(idx) ? gpr[idx] : `CONST_ZERO;
    endcase
  endfunction

  logic issue_fire;
  logic alu_take;
  logic next_ir_valid;

  // Constant destinations are never busy but still wait on their sources
  assign issue_fire = ir_valid && !busy_ext[ir.srca] && !busy_ext[ir.srcb] && !busy_ext[ir.dest];
  assign alu_take   = alu_valid_i && alu_ready_o && in_space(alu_instr_i.dest);

  always_comb begin
    next_ir_valid = ir_valid;
    if (issue_fire && ir.len == 4'h0) begin
      next_ir_valid = 1'b0;
    end
    if (alu_take) begin
      next_ir_valid = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ir_valid    <= 1'b0;
      ir          <= '0;
      alu_ready_o <= 1'b1;
    end else if (ce_i) begin
      ir_valid    <= next_ir_valid;
      // A new instruction waits until the previous vector has left
      alu_ready_o <= !next_ir_valid;
      if (alu_take) begin
        ir <= alu_instr_i;
      end else if (issue_fire) begin
        ir.len  <= ir.len - 4'h1;
        ir.dest <= ir.dest + 6'h01;
        ir.srca <= ir.sca ? ir.srca : ir.srca + 6'h01;
        ir.srcb <= ir.scb ? ir.srcb : ir.srcb + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      issue_valid_o  <= 1'b0;
      issue_opcode_o <= 4'h0;
      issue_dest_o   <= 6'h00;
      issue_a_o      <= 64'h0000_0000_0000_0000;
      issue_b_o      <= 64'h0000_0000_0000_0000;
    end else if (ce_i) begin
      issue_valid_o <= issue_fire;
      if (issue_fire) begin
        issue_opcode_o <= ir.opcode;
        issue_dest_o   <= ir.dest;
        issue_a_o      <= operand(ir.srca);
        issue_b_o      <= operand(ir.srcb);
      end
    end
  end

  // Scoreboard: reservation at element issue beats a same-cycle release
  for (genvar g = 0; g < `GPR_COUNT; g++) begin : g_sb
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        busy[g] <= 1'b0;
      end else if (ce_i) begin
        if (issue_fire && ir.dest == 6'(g)) begin
          busy[g] <= 1'b1;
        end else if (result_i.valid && result_i.dest == 6'(g)) begin
          busy[g] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_user_cnt_write;
    ce_i && priv_viol;
  endsequence

  sequence s_flag_and_int;
    flag_p && interrupt_o;
  endsequence

  a_priv_trap: assert property (s_user_cnt_write |=> s_flag_and_int)
    else $error("user counter write did not trap");
  a_priv_nowrite: assert property (ce_i && priv_viol && cop_req_i.regnum == `REG_WALL
    |=> wall_time_counter == $past(wall_time_counter) + `CNT_W'(1))
    else $error("user write altered wall time counter");
  a_wall_tick: assert property (ce_i && !wall_wr |=> wall_time_counter == $past(wall_time_counter) + `CNT_W'(1))
    else $error("wall time counter missed an increment");
  a_timer_wrap: assert property (ce_i && timer_wrap |=> elapsed_cycle_timer == '0 && flag_t && interrupt_o)
    else $error("timer wrap did not raise timer flag");
  a_status_hold: assert property (ce_i && (!user_mode_i || interrupt_o) |=> $stable(fpu_status_word))
    else $error("status word changed while held");
  a_ovf_discard: assert property (flag_o |-> !res_we)
    else $error("result written after overflow");
  a_ovf_record: assert property (ce_i && ovf_event && !flag_o
    |=> rov == $past(result_i.dest) && flag_o && interrupt_o)
    else $error("overflow destination not recorded");
  a_rd_stall: assert property (ce_i && rd_stall |=> !writeback_stage_advance_o && !cop_data_oe_o)
    else $error("busy source read not stalled");
  a_cnt_upper: assert property (ce_i && cop_rd && !rd_stall && cop_req_i.op == fpu_regs_pkg::COP_STORE &&
    (cop_req_i.regnum == `REG_WALL || cop_req_i.regnum == `REG_ELAPSED)
    |=> cop_data_o[63:64-`CNT_ZERO_BITS] == '0)
    else $error("counter store upper bits not zero");
  a_sb_reserve: assert property (ce_i && issue_fire && is_gpr(ir.dest) |=> busy_ext[$past(ir.dest)])
    else $error("issued element not reserved");
  a_const_noreserve: assert property (ce_i && issue_fire && !is_gpr(ir.dest) && !result_i.valid
    |=> busy == $past(busy))
    else $error("constant destination reserved a register");

endmodule

`default_nettype wire
